// ### rtl/lsea_pkg.sv
// Package for the load/store byte-order and alignment checker
package lsea_pkg;

  // Access size encoding
  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_HALF,
    SZ_WORD,
    SZ_DWORD
  } lsea_size_e;

  // Access class: decides which alignment checks apply
  typedef enum logic [2:0] {
    CL_ORDINARY,   // Ordinary, unprivileged, acquire/release single access
    CL_EXCLUSIVE,  // Exclusive or acquire-exclusive access
    CL_STRICT,     // Literal, doubleword, multiple, stack, coprocessor, fp, lazy fp
    CL_TABLE,      // Byte or halfword table branch
    CL_SYSCTL      // Control-space bus access
  } lsea_class_e;

  // Register byte reversal operations
  typedef enum logic [1:0] {
    RV_NONE,
    RV_WORD,       // byte_reverse_word
    RV_LOW_SIGNED, // byte_reverse_low_half_signed
    RV_EACH_HALF   // byte_reverse_each_half
  } lsea_rev_e;

  localparam int         ADDR_W     = 32;
  localparam int         DATA_W     = 32;
  localparam logic       ENDIAN_LE  = 1'h0;
  localparam logic       ENDIAN_BE  = 1'h1;
  localparam logic [1:0] HALF_MASK  = 2'h1;
  localparam logic [1:0] WORD_MASK  = 2'h3;
  localparam logic [1:0] ZERO_LOW   = 2'h0;
  localparam logic       FETCH_BIT0 = 1'h0;

  // Data access request from the pipeline
  typedef struct packed {
    logic                valid;
    logic                write;
    logic [ADDR_W-1:0]   addr;
    lsea_size_e          size;
    lsea_class_e         cls;
    logic                deviceMem;
    logic [DATA_W-1:0]   wdata;
  } lsea_req_s;

  // Data access issued to the memory system
  typedef struct packed {
    logic                valid;
    logic                write;
    logic [ADDR_W-1:0]   addr;
    lsea_size_e          size;
    logic [DATA_W-1:0]   wdata;
  } lsea_mem_s;

endpackage

// ### rtl/lsea_checker.sv
// Load/store byte-order conversion, alignment fault and fetch path
`timescale 1ns/1ps

module lsea_checker #(
  parameter bit  STRAP_ENDIAN = 1'b0,   // Use the strap input rather than the constant
  parameter bit  FIXED_ENDIAN = 1'b0,   // Constant order when not strapped
  parameter bit  MAIN_EXT     = 1'b1    // Main extension present
) (
  input  wire logic                          clk,             // Core clock
  input  wire logic                          reset_n,         // Synchronous reset, active low
  input  wire logic                          endianStrap,     // Byte-order strap pin
  input  wire logic                          unalignedTrapEnable, // Trap enable from core
  input  wire lsea_pkg::lsea_req_s           req,             // Data access request
  output logic                               reqReady,        // Request taken
  output lsea_pkg::lsea_mem_s                memReq,          // Access to memory system
  input  wire logic                          memReady,        // Memory takes access
  input  wire logic                          memRvalid,       // Read data valid
  input  wire logic [lsea_pkg::DATA_W-1:0]   memRdata,        // Raw read data
  output logic                               alignFault,      // Alignment fault pulse
  output logic                               rdataValid,      // Converted read data valid
  output logic [lsea_pkg::DATA_W-1:0]        rdata,           // Converted read data
  input  wire logic                          fetchValid,      // Fetch request
  input  wire logic [lsea_pkg::ADDR_W-1:0]   fetchAddr,       // Fetch address
  output logic                               fetchReqValid,   // Fetch to memory
  output logic [lsea_pkg::ADDR_W-1:0]        fetchReqAddr,    // Halfword-aligned fetch address
  input  wire logic                          fetchRvalid,     // Fetch data valid
  input  wire logic [15:0]                   fetchRbytes,     // Fetched halfword, lower byte first
  output logic                               instrValid,      // Instruction halfword valid
  output logic [15:0]                        instrHalf,       // Assembled instruction halfword
  input  wire logic [1:0]                    revOp,           // Reversal operation select
  input  wire logic [lsea_pkg::DATA_W-1:0]   revIn,           // Reversal operand
  output logic [lsea_pkg::DATA_W-1:0]        revOut,          // Reversal result
  output logic                               dataEndianIndicator // Reported data byte order
);

  ////////////////////////////////////////////////////////////////////////
  // Byte-order indicator
  // Indicator reads little-endian for one cycle after release, then holds
  logic strapMeta_r, strapSync_r, endian_r, endian_nxt, endianTaken_r, endianTaken_nxt;

  // Strap passes two flops; captured once, after reset release
  always_comb begin
    endian_nxt      = endian_r;
    endianTaken_nxt = endianTaken_r;
    if (!endianTaken_r) begin
      endian_nxt      = STRAP_ENDIAN ? strapSync_r : FIXED_ENDIAN;
      endianTaken_nxt = 1'b1;
    end
  end

  // Sync flops run through reset, so the strap has settled by release;
  // the indicator then loads once and ignores later strap movement
  always_ff @(posedge clk) begin
    strapMeta_r <= endianStrap;
    strapSync_r <= strapMeta_r;
    if (!reset_n) begin
      endian_r      <= lsea_pkg::ENDIAN_LE;
      endianTaken_r <= 1'b0;
    end else begin
      endian_r      <= endian_nxt;
      endianTaken_r <= endianTaken_nxt;
    end
  end

  assign dataEndianIndicator = endian_r;

  ////////////////////////////////////////////////////////////////////////
  // Conversion helpers
  // Halfword result leaves the upper bytes zero; only the low half is used
  function automatic logic [31:0] swapElems(input logic [31:0] d, input lsea_pkg::lsea_size_e sz);
    logic [31:0] r;
    r = d;
    if (sz == lsea_pkg::SZ_HALF) begin
      r = {16'h0000, d[7:0], d[15:8]};
    end else if (sz != lsea_pkg::SZ_BYTE) begin
      r = {d[7:0], d[15:8], d[23:16], d[31:24]};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Alignment checks
  // Byte accesses never fault except in the strict class, which checks word alignment for every size
  logic misHalf, misWord, isStrict, loose, fault, bigData;

  // Fault decode: exclusive and strict classes and doublewords always check, other ones only when trapped, on device memory or without the main extension
  always_comb begin
    misHalf  = (req.addr[1:0] & lsea_pkg::HALF_MASK) != lsea_pkg::ZERO_LOW;
    misWord  = (req.addr[1:0] & lsea_pkg::WORD_MASK) != lsea_pkg::ZERO_LOW;
    isStrict = (req.cls == lsea_pkg::CL_STRICT) || (req.size == lsea_pkg::SZ_DWORD);
    loose    = unalignedTrapEnable || !MAIN_EXT || req.deviceMem;
    fault    = 1'b0;
    if (req.cls == lsea_pkg::CL_EXCLUSIVE) begin
      fault = (req.size == lsea_pkg::SZ_HALF) ? misHalf : (req.size != lsea_pkg::SZ_BYTE) && misWord;
    end else if (isStrict) begin
      fault = misWord;
    end else if (req.size == lsea_pkg::SZ_HALF) begin
      fault = misHalf && loose;
    end else if (req.size == lsea_pkg::SZ_WORD) begin
      fault = misWord && loose;
    end
    bigData = (endian_r == lsea_pkg::ENDIAN_BE) && (req.cls != lsea_pkg::CL_SYSCTL);
  end

  ////////////////////////////////////////////////////////////////////////
  // Data path: one access at a time, each element issued whole
  // Big-endian swap is applied on the way out and on the way back
  typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT} lsea_state_e;
  lsea_state_e          state_r, state_nxt;
  lsea_pkg::lsea_mem_s  memReq_r, memReq_nxt;
  logic                 big_r, big_nxt, fault_r, fault_nxt, rv_r, rv_nxt;
  lsea_pkg::lsea_size_e rsize_r, rsize_nxt;
  logic [31:0]          rdata_r, rdata_nxt;

  // Ready only when idle: one access outstanding keeps ordering trivial
  assign reqReady = (state_r == ST_IDLE);

  // Next state and beat build-up; the pipeline splits multi-word transfers
  // into word requests, so no burst counter is kept here
  always_comb begin
    state_nxt  = state_r;
    memReq_nxt = memReq_r;
    big_nxt    = big_r;
    rsize_nxt  = rsize_r;
    fault_nxt  = 1'b0;
    rv_nxt     = 1'b0;
    rdata_nxt  = rdata_r;
    case (state_r)
      ST_IDLE: begin
        if (req.valid) begin
          if (fault) begin
            // Faulting access is dropped, nothing reaches memory
            fault_nxt = 1'b1;
          end else begin
            // doubleword sent as word beats by pipeline
            memReq_nxt.valid = 1'b1;
            memReq_nxt.write = req.write;
            memReq_nxt.addr  = req.addr;
            memReq_nxt.size  = (req.size == lsea_pkg::SZ_DWORD) ? lsea_pkg::SZ_WORD : req.size;
            memReq_nxt.wdata = bigData ? swapElems(req.wdata, req.size) : req.wdata;
            big_nxt          = bigData;
            rsize_nxt        = memReq_nxt.size;
            state_nxt        = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        // Beat stands until memory takes it
        if (memReady) begin
          memReq_nxt.valid = 1'b0;
          state_nxt        = memReq_r.write ? ST_IDLE : ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Read data converted with the size the beat went out with
        // each word returned whole
        // next word is a new access
        if (memRvalid) begin
          rdata_nxt = big_r ? swapElems(memRdata, rsize_r) : memRdata;
          rv_nxt    = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Registers only; every data-path output comes from here
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r  <= ST_IDLE;
      memReq_r <= '0;
      big_r    <= 1'b0;
      rsize_r  <= lsea_pkg::SZ_BYTE;
      fault_r  <= 1'b0;
      rv_r     <= 1'b0;
      rdata_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      memReq_r <= memReq_nxt;
      big_r    <= big_nxt;
      rsize_r  <= rsize_nxt;
      fault_r  <= fault_nxt;
      rv_r     <= rv_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Registered data-path outputs
  assign memReq     = memReq_r;
  assign alignFault = fault_r;
  assign rdataValid = rv_r;
  assign rdata      = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Fetch path: halfwords captured whole in one flop stage
  // Fetch order never depends on the data byte-order setting
  logic        fv_r, fv_nxt, iv_r, iv_nxt;
  logic [31:0] fa_r, fa_nxt;
  logic [15:0] ih_r, ih_nxt;

  // One-stage pipe with no handshake: a fetch the memory drops must be reissued
  always_comb begin
    fv_nxt = fetchValid;
    fa_nxt = {fetchAddr[31:1], lsea_pkg::FETCH_BIT0};
    iv_nxt = fetchRvalid;
    ih_nxt = fetchRvalid ? fetchRbytes : ih_r;
    // old or new first half seen whole
  end

  // Fetch registers; the halfword is held between returns
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fv_r <= 1'b0;
      fa_r <= '0;
      iv_r <= 1'b0;
      ih_r <= '0;
    end else begin
      fv_r <= fv_nxt;
      fa_r <= fa_nxt;
      iv_r <= iv_nxt;
      ih_r <= ih_nxt;
    end
  end

  // Registered fetch outputs
  assign fetchReqValid = fv_r;
  assign fetchReqAddr  = fa_r;
  assign instrValid    = iv_r;
  assign instrHalf     = ih_r;

  ////////////////////////////////////////////////////////////////////////
  // Register byte reversal, one cycle registered
  // Works on register values only, never on memory traffic
  logic [31:0] rev_r, rev_nxt;

  // Reversal select; RV_NONE falls to the default and passes the operand through
  always_comb begin
    case (lsea_pkg::lsea_rev_e'(revOp))
      lsea_pkg::RV_WORD:       rev_nxt = {revIn[7:0], revIn[15:8], revIn[23:16], revIn[31:24]};
      lsea_pkg::RV_LOW_SIGNED: rev_nxt = {{16{revIn[7]}}, revIn[7:0], revIn[15:8]};
      lsea_pkg::RV_EACH_HALF:  rev_nxt = {revIn[23:16], revIn[31:24], revIn[7:0], revIn[15:8]};
      default:                 rev_nxt = revIn;
    endcase
  end

  // One cycle of latency, traded for a short path from the operand bus
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rev_r <= '0;
    end else begin
      rev_r <= rev_nxt;
    end
  end

  // Registered reversal result
  assign revOut = rev_r;

endmodule

// ### verification/lsea_mem_model.sv
// Partner memory and fetch port facing the byte-order checker
`timescale 1ns/1ps
module lsea_mem_model (
  input  wire logic                clk,           // Core clock
  input  wire logic                reset_n,       // Sync reset, active low
  input  wire logic                slow,          // Stall every access two cycles
  input  wire lsea_pkg::lsea_mem_s memReq,        // Access from the block
  output logic                     memReady,      // Access taken
  output logic                     memRvalid,     // Read return pulse
  output logic [31:0]              memRdata,      // Read data
  input  wire logic                fetchReqValid, // Fetch request
  input  wire logic [31:0]         fetchReqAddr,  // Fetch address
  output logic                     fetchRvalid,   // Fetch return pulse
  output logic [15:0]              fetchRbytes    // Fetched halfword
);
  logic [31:0] mem_r [16];
  logic [1:0]  waitCnt_r;
  ////////////////////////////////////////
  // Ready after the stall so slow slaves are covered too
  assign memReady = memReq.valid && waitCnt_r == (slow ? 2'h2 : 2'h0);
  always_ff @(posedge clk) begin
    waitCnt_r <= (memReq.valid && !memReady) ? waitCnt_r + 2'h1 : 2'h0;
    memRvalid <= reset_n && memReady && !memReq.write;
    // Idle data toggles so stale values never look valid
    memRdata  <= (memReady && !memReq.write) ? mem_r[memReq.addr[5:2]] : ~memRdata;
    if (memReady && memReq.write)
      mem_r[memReq.addr[5:2]] <= memReq.wdata;
  end
  always_ff @(posedge clk) begin
    fetchRvalid <= reset_n && fetchReqValid;
    fetchRbytes <= fetchReqAddr[1] ? mem_r[fetchReqAddr[5:2]][31:16] : mem_r[fetchReqAddr[5:2]][15:0];
  end
endmodule

// ### verification/lsea_checker_sva.sv
// Port-level assertions for the byte-order checker
`timescale 1ns/1ps
module lsea_checker_sva (
  input wire logic                clk,                 // Core clock
  input wire logic                reset_n,             // Sync reset
  input wire logic                unalignedTrapEnable, // Trap enable
  input wire lsea_pkg::lsea_req_s req,                 // Data request
  input wire logic                reqReady,            // Request taken
  input wire lsea_pkg::lsea_mem_s memReq,              // Memory access
  input wire logic                alignFault,          // Fault pulse
  input wire logic                fetchValid,          // Fetch in
  input wire logic [31:0]         fetchAddr,           // Fetch address
  input wire logic                fetchReqValid,       // Fetch out
  input wire logic [31:0]         fetchReqAddr,        // Fetch out address
  input wire logic                fetchRvalid,         // Fetch return
  input wire logic [15:0]         fetchRbytes,         // Fetch bytes
  input wire logic                instrValid,          // Halfword valid
  input wire logic [15:0]         instrHalf,           // Halfword
  input wire logic [1:0]          revOp,               // Reversal select
  input wire logic [31:0]         revIn,               // Reversal operand
  input wire logic [31:0]         revOut,              // Reversal result
  input wire logic                dataEndianIndicator  // Byte order
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic        mis;
  logic [31:0] rp_r;
  ////////////////////////////////////////
  // Misalignment for the size, byte never misaligned
  assign mis = req.size != lsea_pkg::SZ_BYTE && (req.addr[1:0] &
               (req.size == lsea_pkg::SZ_HALF ? lsea_pkg::HALF_MASK : lsea_pkg::WORD_MASK)) != 2'h0;
  // Operand one cycle back, result is registered
  always_ff @(posedge clk) rp_r <= revIn;
  sequence s_take; req.valid && reqReady; endsequence
  sequence s_bad; s_take ##0 mis; endsequence
  property p_excl; s_bad ##0 req.cls == lsea_pkg::CL_EXCLUSIVE |=> alignFault && !memReq.valid; endproperty
  a_excl: assert property (p_excl) else $error("exclusive misalign no fault");
  property p_strict; s_bad ##0 (req.cls == lsea_pkg::CL_STRICT || req.size == lsea_pkg::SZ_DWORD) |=> alignFault;
  endproperty
  a_strict: assert property (p_strict) else $error("strict misalign no fault");
  property p_trap; s_bad ##0 unalignedTrapEnable && req.cls inside {lsea_pkg::CL_ORDINARY, lsea_pkg::CL_TABLE}
    |=> alignFault; endproperty
  a_trap: assert property (p_trap) else $error("trap misalign no fault");
  property p_dev; s_bad ##0 req.deviceMem |=> alignFault && !memReq.valid; endproperty
  a_dev: assert property (p_dev) else $error("device misalign issued");
  property p_ok; s_take ##0 req.cls == lsea_pkg::CL_ORDINARY && !unalignedTrapEnable && !req.deviceMem &&
    req.size != lsea_pkg::SZ_DWORD |=> !alignFault && memReq.valid; endproperty
  a_ok: assert property (p_ok) else $error("ordinary access refused");
  property p_fetch; fetchValid |=> fetchReqValid && fetchReqAddr == ($past(fetchAddr) & ~32'h1); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_instr; fetchRvalid |=> instrValid && instrHalf == $past(fetchRbytes); endproperty
  a_instr: assert property (p_instr) else $error("fetch halfword order");
  property p_rw; revOp == 2'h1 |=> revOut == {rp_r[7:0], rp_r[15:8], rp_r[23:16], rp_r[31:24]}; endproperty
  a_rw: assert property (p_rw) else $error("word reversal wrong");
  property p_rs; revOp == 2'h2 |=> revOut == {{16{rp_r[7]}}, rp_r[7:0], rp_r[15:8]}; endproperty
  a_rs: assert property (p_rs) else $error("signed reversal wrong");
  property p_rh; revOp == 2'h3 |=> revOut == {rp_r[23:16], rp_r[31:24], rp_r[7:0], rp_r[15:8]}; endproperty
  a_rh: assert property (p_rh) else $error("half pair reversal wrong");
  property p_end; $past(reset_n) && $past(reset_n, 2) |-> $stable(dataEndianIndicator); endproperty
  a_end: assert property (p_end) else $error("byte order changed");
endmodule
bind lsea_checker lsea_checker_sva u_sva (.clk, .reset_n, .unalignedTrapEnable, .req, .reqReady, .memReq,
  .alignFault, .fetchValid, .fetchAddr, .fetchReqValid, .fetchReqAddr, .fetchRvalid, .fetchRbytes, .instrValid,
  .instrHalf, .revOp, .revIn, .revOut, .dataEndianIndicator);

// ### verification/test_lsea_checker.sv
// Self-checking bench for the byte-order and alignment checker
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; $display("unexpected %s %h %h", n, e, a); end end
module test_lsea_checker;
  logic clk = 1'b0, reset_n = 1'b0, endianStrap = 1'b1, unalignedTrapEnable = 1'b0, slow = 1'b0;
  logic reqReady, memReady, memRvalid, alignFault, rdataValid, fetchValid = 1'b0;
  logic fetchReqValid, fetchRvalid, instrValid, dataEndianIndicator;
  logic [31:0] memRdata, rdata, fetchAddr = '0, fetchReqAddr, revIn = '0, revOut, rd;
  logic [15:0] fetchRbytes, instrHalf;
  logic [1:0]  revOp = '0;
  lsea_pkg::lsea_req_s req = '0;
  lsea_pkg::lsea_mem_s memReq;
  int fails = 0, n_compared = 0, cyc = 0;
  ////////////////////////////////////////
  // Strapped big-endian so conversion shows on the bus
  lsea_checker #(.STRAP_ENDIAN(1'b1)) uut (.clk, .reset_n, .endianStrap, .unalignedTrapEnable, .req, .reqReady,
    .memReq, .memReady, .memRvalid, .memRdata, .alignFault, .rdataValid, .rdata, .fetchValid, .fetchAddr,
    .fetchReqValid, .fetchReqAddr, .fetchRvalid, .fetchRbytes, .instrValid, .instrHalf, .revOp, .revIn, .revOut,
    .dataEndianIndicator);
  lsea_mem_model mdl (.clk, .reset_n, .slow, .memReq, .memReady, .memRvalid, .memRdata, .fetchReqValid,
    .fetchReqAddr, .fetchRvalid, .fetchRbytes);
  // Clock and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One access; fl is {write, device, trap, fault expected}
  task automatic acc(input logic [3:0] fl, input logic [31:0] a, input lsea_pkg::lsea_size_e s,
                     input lsea_pkg::lsea_class_e c, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{1'b1, fl[3], a, s, c, fl[2], wd};
    unalignedTrapEnable <= fl[1];
    @(negedge clk);
    while (!reqReady && k < 30) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    req.valid <= 1'b0;
    @(negedge clk);
    `CHK("fault", fl[0], alignFault)
    while (!fl[0] && !(fl[3] ? reqReady : rdataValid) && k < 60) begin
      @(negedge clk);
      k++;
    end
    rd = rdata;
    `CHK("done", 1'b1, k < 60)
  endtask
  task automatic t_endian;
    `CHK("order", 1'b1, dataEndianIndicator)
    endianStrap <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK("order held", 1'b1, dataEndianIndicator)
    $display("t_endian done");
  endtask
  // Slow slave on the first word; control space must skip the swap
  task automatic t_conv;
    slow <= 1'b1;
    acc(4'h8, 32'h4, lsea_pkg::SZ_WORD, lsea_pkg::CL_ORDINARY, 32'h11223344);
    `CHK("word", 32'h44332211, mdl.mem_r[1])
    slow <= 1'b0;
    acc(4'h0, 32'h4, lsea_pkg::SZ_WORD, lsea_pkg::CL_ORDINARY, 32'h0);
    `CHK("word rd", 32'h11223344, rd)
    acc(4'h8, 32'h8, lsea_pkg::SZ_HALF, lsea_pkg::CL_ORDINARY, 32'haabb);
    `CHK("half", 16'hbbaa, mdl.mem_r[2][15:0])
    acc(4'h0, 32'h8, lsea_pkg::SZ_HALF, lsea_pkg::CL_ORDINARY, 32'h0);
    `CHK("half rd", 32'haabb, rd)
    acc(4'h8, 32'h10, lsea_pkg::SZ_BYTE, lsea_pkg::CL_ORDINARY, 32'h5a);
    `CHK("byte", 8'h5a, mdl.mem_r[4][7:0])
    acc(4'h8, 32'h14, lsea_pkg::SZ_DWORD, lsea_pkg::CL_STRICT, 32'h01020304);
    `CHK("dword", 32'h04030201, mdl.mem_r[5])
    acc(4'h8, 32'hc, lsea_pkg::SZ_WORD, lsea_pkg::CL_SYSCTL, 32'hc0deb0a5);
    `CHK("sysctl", 32'hc0deb0a5, mdl.mem_r[3])
    $display("t_conv done");
  endtask
  task automatic t_faults;
    acc(4'h1, 32'h21, lsea_pkg::SZ_HALF, lsea_pkg::CL_EXCLUSIVE, 32'h0);
    acc(4'h9, 32'h22, lsea_pkg::SZ_WORD, lsea_pkg::CL_EXCLUSIVE, 32'h0);
    acc(4'h1, 32'h22, lsea_pkg::SZ_WORD, lsea_pkg::CL_STRICT, 32'h0);
    acc(4'h1, 32'h26, lsea_pkg::SZ_DWORD, lsea_pkg::CL_ORDINARY, 32'h0);
    acc(4'h9, 32'h21, lsea_pkg::SZ_WORD, lsea_pkg::CL_STRICT, 32'h0);
    acc(4'h3, 32'h23, lsea_pkg::SZ_HALF, lsea_pkg::CL_ORDINARY, 32'h0);
    acc(4'h3, 32'h23, lsea_pkg::SZ_HALF, lsea_pkg::CL_TABLE, 32'h0);
    acc(4'hb, 32'h23, lsea_pkg::SZ_WORD, lsea_pkg::CL_ORDINARY, 32'h0);
    acc(4'h0, 32'h23, lsea_pkg::SZ_WORD, lsea_pkg::CL_ORDINARY, 32'h0);
    acc(4'hd, 32'h22, lsea_pkg::SZ_WORD, lsea_pkg::CL_ORDINARY, 32'h0);
    $display("t_faults done");
  endtask
  // Odd fetch address; word at 0xc was stored little-endian
  task automatic t_fetch;
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr <= 32'hf;
    @(posedge clk);
    fetchValid <= 1'b0;
    @(negedge clk);
    `CHK("fetch addr", 32'he, fetchReqAddr)
    repeat (2) @(negedge clk);
    `CHK("instr ok", 1'b1, instrValid)
    `CHK("instr", 16'hc0de, instrHalf)
    $display("t_fetch done");
  endtask
  task automatic t_rev;
    logic [31:0] want [4];
    want = '{32'hb8a6f412, 32'hffffb8a6, 32'hf412b8a6, 32'h12f4a6b8};
    // Fourth pass wraps the select to zero: operand passes straight through
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      revOp <= 2'(i + 1);
      revIn <= 32'h12f4a6b8;
      @(posedge clk);
      @(negedge clk);
      `CHK("rev", want[i], revOut)
    end
    $display("t_rev done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_endian;
    t_conv;
    t_faults;
    t_fetch;
    t_rev;
    give_verdict;
  end
endmodule
